// ==== hdl/asb_pkg.sv ====
// Purpose: constants for the serial channel baud and extension control block
// Assumes: registers sit one per 32-bit word on the bus
// Notes: index constants are word indexes; byte address is index times four
package asb_pkg;
	// register indexes and byte addresses
	localparam logic [7:0] CTRLB_IDX = 8'h02;
	localparam logic [7:0] EXT_IDX = 8'h12;
	localparam logic [7:0] STAT_IDX = 8'h20;
	localparam logic [7:0] CFG_IDX = 8'h21;
	localparam logic [7:0] TC_IDX = 8'h22;
	localparam logic [7:0] CTRLB_ADDR = {CTRLB_IDX[5:0], 2'b00};
	localparam logic [7:0] EXT_ADDR = {EXT_IDX[5:0], 2'b00};
	localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
	localparam logic [7:0] CFG_ADDR = {CFG_IDX[5:0], 2'b00};
	localparam logic [7:0] TC_ADDR = {TC_IDX[5:0], 2'b00};
	// serial_control_b fields
	localparam int CB_PS = 5;
	localparam int CB_PAR = 4;
	localparam int CB_DR = 3;
	localparam int CB_SS_LO = 0;
	localparam logic [2:0] SS_RESET = 3'h7;
	localparam logic [2:0] SS_EXT = 3'h7;
	// serial0_extension_control fields
	localparam int EX_RECEIVE_DATA_FULL_FLAG_INH = 7;
	localparam int EX_DCD_DIS = 6;
	localparam int EX_CTS_DIS = 5;
	localparam int EX_X1 = 4;
	localparam int EX_BRG = 3;
	localparam int EX_BRK_EN = 2;
	localparam int EX_BRK_DET = 1;
	localparam int EX_SEND_BRK = 0;
	localparam logic [7:0] EXT_RESET = 8'h00;
	// own config register fields
	localparam int CF_DMA_MEMIO = 0;
	localparam int CF_CH1_CLK_DIS = 1;
	localparam int CF_CH1_CTS_EN = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;
	localparam logic [15:0] TC_RESET = 16'h0000;
	// own status register fields
	localparam int ST_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
	localparam int ST_CH0_CLEAR_TO_SEND_INPUT = 1;
	localparam int ST_CARRIER_DETECT_INPUT = 2;
	localparam int ST_CTS1 = 3;
	localparam int ST_BRK = 4;
	// division counts
	localparam logic [4:0] PRESC_LOW = 5'h0a;
	localparam logic [4:0] PRESC_HIGH = 5'h1e;
	localparam logic [5:0] SAMP_LOW = 6'h10;
	localparam logic [6:0] SAMP_HIGH = 7'h40;
	localparam logic [3:0] BREAK_BITS = 4'ha;
endpackage : asb_pkg

// ==== hdl/asb_top.sv ====
// Purpose: baud selection, clear-to-send readback and extension control of serial channel 0
// Assumes: Avalon-MM slave with waitrequest; pins synchronous to i_clk
// Notes: one wait state on every access
// What this block does
// [RULE1] reading the clear-to-send/prescale bit returns the live clear-to-send pin
// [RULE2] clear-to-send high forces the transmit buffer empty flag to 0
// [RULE3] channel 1 clear-to-send readback valid only with its enable bit set
// [RULE4] reset never changes the clear-to-send readback; it follows the pin
// [RULE5] written prescale bit: 1 divides by 30, 0 by 10; reset clears it
// [RULE6] parity sense 0 even, 1 odd; no parity enable; reset clears it
// [RULE7] sampling divide bit 0 gives divide by 16, 1 gives 64; reset clears it
// [RULE8] reset sets the three source/speed select bits to 1
// [RULE9] source/speed codes 0 to 6 divide by 1 to 64; 7 means external clock
// [RULE10] after reset both shared clock pins are clock inputs
// [RULE11] DMA memory/IO mode turns channel 0 clock pin into DMA request
// [RULE12] channel 1 clock disable turns channel 1 clock pin into transfer-end output
// [RULE13] bit rate is clock over prescaler, source/speed divider and sampling divider
// [RULE14] byte-wide extension register of channel 0, reset to zero
// [RULE15] extension bit 7 at 0 inhibits receive-full interrupt, 1 allows it
// [RULE16] extension bit 3 at 1 selects 16-bit baud counter mode
// [RULE17] extension bit 2 at 0 enables break feature, 1 disables it
// [RULE18] extension bits 6 and 5 at 0 let carrier/clear-to-send gate rx/tx
// [RULE19] extension bit 4 at 1 uses external clock directly as bit clock
// [RULE20] extension bit 1 is read-only break status; bit 0 holds transmit low
//
// Our own choice: the Avalon-MM register port.
module asb_top (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_ch0_clear_to_send_input,
	input wire logic i_carrier_detect_input,
	input wire logic i_clocked_serial_receive_pin,
	input wire logic i_tx_buffer_empty,
	input wire logic i_rx_data_full,
	input wire logic i_tx_serial_data,
	input wire logic i_rx_serial_line,
	input wire logic i_ch0_ext_clock_pin,
	input wire logic i_dma_transfer_end,
	output logic o_transmit_buffer_empty_flag,
	output logic o_tx_enable,
	output logic o_rx_enable,
	output logic o_rx_full_irq_req,
	output logic o_parity_sense,
	output logic o_sample_tick,
	output logic o_bit_tick,
	output logic o_serial_transmit_line,
	output logic o_ch0_clk_pin_is_dma,
	output logic o_dma_request_active,
	output logic o_ch1_ext_clock_pin_o,
	output logic o_ch1_ext_clock_pin_oe,
	output logic o_break_detected
);
	logic [5:0] ctrlb_r;
	logic [7:0] ext_r;
	logic [2:0] cfg_r;
	logic [15:0] tc_r;
	logic brk_r;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic wr_acc;
	logic rd_start;
	logic rd_acc;
	logic ext_q1_r;
	logic ext_q2_r;
	logic ext_edge;
	logic [4:0] presc_cnt_r;
	logic presc_tick_r;
	logic [4:0] presc_gap_r;
	logic [5:0] ss_cnt_r;
	logic [6:0] ss_div;
	logic int_tick_r;
	logic [15:0] brg_cnt_r;
	logic src_tick;
	logic [6:0] samp_cnt_r;
	logic [6:0] samp_lim;
	logic [2:0] ss;
	logic x1_direct;
	logic [3:0] brk_cnt_r;
	logic brk_set;

	assign ss = ctrlb_r[asb_pkg::CB_SS_LO +: 3];
	assign wr_acc = i_avs_write && !waitreq_r;
	assign rd_start = i_avs_read && waitreq_r;
	assign rd_acc = i_avs_read && !waitreq_r;

	// one wait state: low for exactly one cycle per request
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			waitreq_r <= 1'b1;
		end else begin
			waitreq_r <= !((i_avs_read || i_avs_write) && waitreq_r);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrlb_r <= {1'b0, 1'b0, 1'b0, asb_pkg::SS_RESET}; // [RULE5] [RULE6] [RULE7] [RULE8]
		end else if (wr_acc && i_avs_address == asb_pkg::CTRLB_ADDR) begin
			ctrlb_r <= i_avs_writedata[5:0]; // [RULE5]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ext_r <= asb_pkg::EXT_RESET; // [RULE14]
		end else if (wr_acc && i_avs_address == asb_pkg::EXT_ADDR) begin
			ext_r <= {i_avs_writedata[7:2], 1'b0, i_avs_writedata[0]}; // [RULE20]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cfg_r <= asb_pkg::CFG_RESET;
		end else if (wr_acc && i_avs_address == asb_pkg::CFG_ADDR) begin
			cfg_r <= i_avs_writedata[2:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			tc_r <= asb_pkg::TC_RESET;
		end else if (wr_acc && i_avs_address == asb_pkg::TC_ADDR) begin
			tc_r <= i_avs_writedata[15:0];
		end
	end

	// read data captured in the first cycle, stands while waitrequest is low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_start) begin
			if (i_avs_address == asb_pkg::CTRLB_ADDR) begin
				rdata_r <= {26'h0, i_ch0_clear_to_send_input, ctrlb_r[4:0]}; // [RULE1] [RULE4]
			end else if (i_avs_address == asb_pkg::EXT_ADDR) begin
				rdata_r <= {24'h0, ext_r[7:2], brk_r, ext_r[0]}; // [RULE20]
			end else if (i_avs_address == asb_pkg::STAT_ADDR) begin
				rdata_r <= {27'h0, brk_r, cfg_r[asb_pkg::CF_CH1_CTS_EN] & i_clocked_serial_receive_pin, // [RULE3]
					i_carrier_detect_input, i_ch0_clear_to_send_input, o_transmit_buffer_empty_flag};
			end else if (i_avs_address == asb_pkg::CFG_ADDR) begin
				rdata_r <= {29'h0, cfg_r};
			end else if (i_avs_address == asb_pkg::TC_ADDR) begin
				rdata_r <= {16'h0, tc_r};
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end
	end

	assign o_avs_readdata = rdata_r;
	assign o_avs_waitrequest = waitreq_r;

	// external clock edges, ignored while the pin serves the DMA controller
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			// pin idles high: no false edge after reset
			ext_q1_r <= 1'b1;
			ext_q2_r <= 1'b1;
		end else begin
			ext_q1_r <= i_ch0_ext_clock_pin;
			ext_q2_r <= ext_q1_r;
		end
	end
	assign ext_edge = ext_q1_r && !ext_q2_r && !cfg_r[asb_pkg::CF_DMA_MEMIO]; // [RULE11]

	// prescaler: 10 or 30
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			presc_cnt_r <= 5'h00;
			presc_tick_r <= 1'b0;
		end else if (presc_cnt_r >= (ctrlb_r[asb_pkg::CB_PS] ? asb_pkg::PRESC_HIGH : asb_pkg::PRESC_LOW) - 5'h01) begin
			presc_cnt_r <= 5'h00; // [RULE5]
			presc_tick_r <= 1'b1;
		end else begin
			presc_cnt_r <= presc_cnt_r + 5'h01;
			presc_tick_r <= 1'b0;
		end
	end

	// cycles since the last prescaler tick, saturating; checker helper
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			presc_gap_r <= 5'h00;
		end else if (presc_tick_r) begin
			presc_gap_r <= 5'h01;
		end else if (presc_gap_r != 5'h1f) begin
			presc_gap_r <= presc_gap_r + 5'h01;
		end
	end

	// source/speed divider, power of two
	assign ss_div = 7'h01 << ss; // [RULE9]
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ss_cnt_r <= 6'h00;
			int_tick_r <= 1'b0;
		end else if (presc_tick_r && ss_cnt_r >= 6'(ss_div - 7'h01)) begin
			ss_cnt_r <= 6'h00;
			int_tick_r <= 1'b1;
		end else begin
			ss_cnt_r <= presc_tick_r ? ss_cnt_r + 6'h01 : ss_cnt_r;
			int_tick_r <= 1'b0;
		end
	end

	// 16-bit counter mode, period tc_r + 1
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			brg_cnt_r <= 16'h0000;
		end else if (brg_cnt_r >= tc_r) begin
			brg_cnt_r <= 16'h0000;
		end else begin
			brg_cnt_r <= brg_cnt_r + 16'h0001;
		end
	end

	always_comb begin
		if (ss == asb_pkg::SS_EXT) begin
			src_tick = ext_edge; // [RULE9]
		end else if (ext_r[asb_pkg::EX_BRG]) begin
			src_tick = brg_cnt_r >= tc_r; // [RULE16]
		end else begin
			src_tick = int_tick_r; // [RULE13]
		end
	end

	assign x1_direct = ext_r[asb_pkg::EX_X1] && ss == asb_pkg::SS_EXT;
	assign samp_lim = ctrlb_r[asb_pkg::CB_DR] ? asb_pkg::SAMP_HIGH : {1'b0, asb_pkg::SAMP_LOW}; // [RULE7]

	// sampling divider and bit tick
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			samp_cnt_r <= 7'h00;
			o_sample_tick <= 1'b0;
			o_bit_tick <= 1'b0;
		end else begin
			o_sample_tick <= src_tick;
			if (x1_direct) begin
				samp_cnt_r <= 7'h00;
				o_bit_tick <= ext_edge; // [RULE19]
			end else if (src_tick && samp_cnt_r >= samp_lim - 7'h01) begin
				samp_cnt_r <= 7'h00;
				o_bit_tick <= 1'b1; // [RULE13]
			end else begin
				samp_cnt_r <= src_tick ? samp_cnt_r + 7'h01 : samp_cnt_r;
				o_bit_tick <= 1'b0;
			end
		end
	end

	// break detect: line low for a run of bit times
	always_ff @(posedge i_clk) begin
		if (i_srst || i_rx_serial_line || ext_r[asb_pkg::EX_BRK_EN]) begin
			brk_cnt_r <= 4'h0; // [RULE17]
		end else if (o_bit_tick && brk_cnt_r != asb_pkg::BREAK_BITS) begin
			brk_cnt_r <= brk_cnt_r + 4'h1;
		end
	end
	assign brk_set = brk_cnt_r == asb_pkg::BREAK_BITS;

	// cleared by reading the extension register; a new break wins
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			brk_r <= 1'b0;
		end else if (brk_set) begin
			brk_r <= 1'b1; // [RULE20]
		end else if (rd_acc && i_avs_address == asb_pkg::EXT_ADDR) begin
			brk_r <= 1'b0;
		end
	end

	// channel-facing outputs
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_transmit_buffer_empty_flag <= 1'b0;
			o_tx_enable <= 1'b0;
			o_rx_enable <= 1'b0;
			o_rx_full_irq_req <= 1'b0;
			o_parity_sense <= 1'b0;
			o_serial_transmit_line <= 1'b1;
			o_break_detected <= 1'b0;
		end else begin
			o_transmit_buffer_empty_flag <= i_tx_buffer_empty && !i_ch0_clear_to_send_input; // [RULE2]
			o_tx_enable <= ext_r[asb_pkg::EX_CTS_DIS] || !i_ch0_clear_to_send_input; // [RULE18]
			o_rx_enable <= ext_r[asb_pkg::EX_DCD_DIS] || !i_carrier_detect_input; // [RULE18]
			o_rx_full_irq_req <= i_rx_data_full && ext_r[asb_pkg::EX_RECEIVE_DATA_FULL_FLAG_INH]; // [RULE15]
			o_parity_sense <= ctrlb_r[asb_pkg::CB_PAR]; // [RULE6]
			o_serial_transmit_line <= !ext_r[asb_pkg::EX_SEND_BRK] && i_tx_serial_data; // [RULE20]
			o_break_detected <= brk_r;
		end
	end

	// shared pin functions
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_ch0_clk_pin_is_dma <= 1'b0; // [RULE10]
			o_dma_request_active <= 1'b0;
			o_ch1_ext_clock_pin_o <= 1'b0;
			o_ch1_ext_clock_pin_oe <= 1'b0; // [RULE10]
		end else begin
			o_ch0_clk_pin_is_dma <= cfg_r[asb_pkg::CF_DMA_MEMIO]; // [RULE11]
			o_dma_request_active <= cfg_r[asb_pkg::CF_DMA_MEMIO] && !i_ch0_ext_clock_pin; // [RULE11]
			o_ch1_ext_clock_pin_o <= cfg_r[asb_pkg::CF_CH1_CLK_DIS] && i_dma_transfer_end; // [RULE12]
			o_ch1_ext_clock_pin_oe <= cfg_r[asb_pkg::CF_CH1_CLK_DIS]; // [RULE12]
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence ext_write_s;
		i_avs_write && !o_avs_waitrequest && i_avs_address == asb_pkg::EXT_ADDR;
	endsequence
	sequence ctrlb_read_s;
		i_avs_read && o_avs_waitrequest && i_avs_address == asb_pkg::CTRLB_ADDR;
	endsequence

	cts_read_a: assert property (ctrlb_read_s |=> o_avs_readdata[5] == $past(i_ch0_clear_to_send_input)) // [RULE1]
		else $error("clear-to-send readback does not follow pin");
	cts_transmit_buffer_empty_flag_a: assert property (i_ch0_clear_to_send_input |=> !o_transmit_buffer_empty_flag) // [RULE2]
		else $error("empty flag not forced low by clear-to-send");
	presc_gap_a: assert property (presc_tick_r |-> presc_gap_r >= asb_pkg::PRESC_LOW) // [RULE5]
		else $error("prescaler tick faster than divide by ten");
	reset_val_a: assert property (disable iff (1'b0) $past(i_srst) && !i_srst |-> ss == 3'h7 && ext_r == 8'h00 // [RULE8]
		&& ctrlb_r[5:3] == 3'h0) else $error("reset values wrong");
	ext_write_a: assert property (ext_write_s |=> ext_r == {$past(i_avs_writedata[7:2]), 1'b0, // [RULE14]
		$past(i_avs_writedata[0])}) else $error("extension register write lost");
	send_break_a: assert property (ext_r[0] |=> !o_serial_transmit_line) // [RULE20]
		else $error("send break does not hold line low");
	receive_data_full_flag_inhibit_a: assert property (!ext_r[7] |=> !o_rx_full_irq_req) // [RULE15]
		else $error("receive-full request not inhibited");
	ch1_pin_a: assert property (##1 o_ch1_ext_clock_pin_oe == $past(cfg_r[asb_pkg::CF_CH1_CLK_DIS])) // [RULE12]
		else $error("channel 1 pin direction wrong");
	x1_clock_a: assert property (x1_direct && ext_edge |=> o_bit_tick) // [RULE19]
		else $error("direct bit clock missed");
	cts_gate_a: assert property (!ext_r[5] && i_ch0_clear_to_send_input |=> !o_tx_enable) // [RULE18]
		else $error("transmit not gated by clear-to-send");

	wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	transmit_buffer_empty_flag_pass_a: assert property (!i_ch0_clear_to_send_input && i_tx_buffer_empty |=> o_transmit_buffer_empty_flag) // [RULE2]
		else $error("empty flag not passed through");
	parity_out_a: assert property (##1 o_parity_sense == $past(ctrlb_r[asb_pkg::CB_PAR])) // [RULE6]
		else $error("parity sense output wrong");
	rx_gate_a: assert property (!ext_r[asb_pkg::EX_DCD_DIS] && i_carrier_detect_input |=> !o_rx_enable) // [RULE18]
		else $error("receive not gated by carrier detect");
	dma_req_a: assert property (cfg_r[asb_pkg::CF_DMA_MEMIO] && !i_ch0_ext_clock_pin |=> o_dma_request_active) // [RULE11]
		else $error("dma request not passed");
	break_set_a: assert property (brk_set |=> brk_r) // [RULE20]
		else $error("break flag not set");
	break_off_a: assert property (ext_r[asb_pkg::EX_BRK_EN] |=> brk_cnt_r == 4'h0) // [RULE17]
		else $error("break count runs while disabled");
	tx_normal_a: assert property (!ext_r[asb_pkg::EX_SEND_BRK] && i_tx_serial_data |=> o_serial_transmit_line) // [RULE20]
		else $error("transmit line not passed");
endmodule // asb_top

// ==== tb/asb_far.sv ====
// Purpose: far side model: remote serial device and external data clock
// Assumes: every line changes just after a rising i_clk edge
// Notes: data clock stands still outside runs; when stopped it drives the inverted dma request level
module asb_far #(parameter int HALF = 10) (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_stop,
	input wire logic i_no_carrier,
	input wire logic i_brk,
	input wire logic i_dreq,
	output logic o_cts,
	output logic o_dcd,
	output logic o_rxd,
	output logic o_cka
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt_r = 0;
	logic ph_r = 1'b1;
	always @(posedge i_clk) begin
		if (i_run) begin
			cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
			if (cnt_r == HALF - 1)
				ph_r <= ~ph_r;
		end else begin
			cnt_r <= 0;
			ph_r <= ~i_dreq;
		end
	end
	assign o_cka = ph_r;
	assign o_cts = i_stop;
	assign o_dcd = i_no_carrier;
	// mark level when idle, space while breaking
	assign o_rxd = ~i_brk;
endmodule // asb_far

// ==== tb/tb.sv ====
// Purpose: self-checking bench for asb_top
// Assumes: one wait state per access; pin outputs one cycle late
// Notes: tick periods measured between consecutive pulses
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] CB = asb_pkg::CTRLB_ADDR;
	localparam logic [7:0] EX = asb_pkg::EXT_ADDR;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0, wr = 1'b0, run = 1'b0, stop = 1'b1, nocar = 1'b0, brk = 1'b0, dreq = 1'b0;
	logic txe = 1'b1, rxf = 1'b0, txd = 1'b1, clocked_serial_receive_pin = 1'b0, dte = 1'b0;
	logic [31:0] wd = 32'h0, rdata, q;
	logic waitreq, flag, txen, rxen, irq, par, stick, btick, txl, isdma, dmareq, c1o, c1oe, bdet;
	logic cts, dcd, rxd, cka;
	int bad_count = 0, num_checks = 0;
	always #50 i_clk = ~i_clk;
	asb_far u_asb_far (.i_clk(i_clk), .i_run(run), .i_stop(stop), .i_no_carrier(nocar), .i_brk(brk),
		.i_dreq(dreq), .o_cts(cts), .o_dcd(dcd), .o_rxd(rxd), .o_cka(cka));
	asb_top u_asb_top (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_ch0_clear_to_send_input(cts), .i_carrier_detect_input(dcd), .i_clocked_serial_receive_pin(clocked_serial_receive_pin),
		.i_tx_buffer_empty(txe), .i_rx_data_full(rxf), .i_tx_serial_data(txd), .i_rx_serial_line(rxd),
		.i_ch0_ext_clock_pin(cka), .i_dma_transfer_end(dte), .o_transmit_buffer_empty_flag(flag),
		.o_tx_enable(txen), .o_rx_enable(rxen), .o_rx_full_irq_req(irq), .o_parity_sense(par),
		.o_sample_tick(stick), .o_bit_tick(btick), .o_serial_transmit_line(txl), .o_ch0_clk_pin_is_dma(isdma),
		.o_dma_request_active(dmareq), .o_ch1_ext_clock_pin_o(c1o), .o_ch1_ext_clock_pin_oe(c1oe),
		.o_break_detected(bdet));
	task automatic results;
		if (bad_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is sampled low
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= ~w;
		do
			@(posedge i_clk);
		while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic st;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic per(input logic b, input int e);
		int n;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(posedge i_clk);
				n++;
			end while ((b ? btick : stick) !== 1'b1);
		end
		chk(n, e);
	endtask
	initial begin
		#3000000;
		bad_count++;
		results;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		rdc(CB, 32'h27);
		rdc(EX, 32'h00);
		chk({flag, txen}, 2'b00);
		chk({c1oe, isdma}, 2'b00);
		stop <= 1'b0;
		st;
		chk(flag, 1'b1);
		rdc(CB, 32'h07);
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 3; s++) begin
				wrt(CB, (p ? 32'h20 : 32'h00) | 32'(s));
				per(1'b0, (p ? 32'h1e : 32'h0a) << s);
			end
		wrt(CB, 32'h18);
		rdc(CB, 32'h18);
		chk(par, 1'b1);
		per(1'b1, 32'h280);
		wrt(CB, 32'h00);
		per(1'b1, 32'ha0);
		run <= 1'b1;
		wrt(CB, 32'h07);
		per(1'b0, 32'h14);
		per(1'b1, 32'h140);
		wrt(EX, 32'h10);
		per(1'b1, 32'h14);
		brk <= 1'b1;
		repeat (300) @(posedge i_clk);
		chk(bdet, 1'b1);
		brk <= 1'b0;
		st;
		rdc(EX, 32'h12);
		rdc(EX, 32'h10);
		wrt(EX, 32'h14);
		brk <= 1'b1;
		repeat (300) @(posedge i_clk);
		chk(bdet, 1'b0);
		brk <= 1'b0;
		run <= 1'b0;
		wrt(CB, 32'h00);
		wrt(asb_pkg::TC_ADDR, 32'h04);
		wrt(EX, 32'h08);
		per(1'b0, 32'h05);
		wrt(EX, 32'hff);
		rdc(EX, 32'hfd);
		stop <= 1'b1;
		nocar <= 1'b1;
		rxf <= 1'b1;
		st;
		chk({txen, rxen, irq, txl}, 4'he);
		wrt(EX, 32'h00);
		st;
		chk({txen, rxen, irq, txl}, 4'h1);
		stop <= 1'b0;
		nocar <= 1'b0;
		dreq <= 1'b1;
		clocked_serial_receive_pin <= 1'b1;
		dte <= 1'b1;
		wrt(asb_pkg::CFG_ADDR, 32'h07);
		st;
		chk({isdma, dmareq, c1o, c1oe}, 4'hf);
		rdc(asb_pkg::STAT_ADDR, 32'h09);
		wrt(asb_pkg::CFG_ADDR, 32'h00);
		st;
		rdc(asb_pkg::STAT_ADDR, 32'h01);
		chk({isdma, c1oe}, 2'b00);
		rdc(8'hfc, 32'h00);
		results;
	end
endmodule // tb
